// [rtl/olt_pkg.sv]
package olt_pkg;
	// widths
	localparam int MAG_W = 16;
	localparam int CNT_W = 20;
	localparam int REL_W = 15;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// timing
	localparam real TICK_MS = 5.0;
	localparam real REL_DEF_MS = 60.0;
	localparam logic [REL_W-1:0] REL_DEF = REL_W'($rtoi(REL_DEF_MS / TICK_MS));
	localparam logic [REL_W-1:0] REL_MAX = 15'h7530;
	// pick-up and hysteresis, magnitudes in hundredths of nominal current
	localparam logic [MAG_W-1:0] THR_DEF = 16'h0078;
	localparam logic [7:0] DROP_PCT = 8'h61;
	localparam logic [7:0] FULL_PCT = 8'h64;
	localparam logic [11:0] TDIAL_DEF = 12'h064;
	localparam logic [11:0] TDIAL_RD_MIN = 12'h01E;
	localparam logic [CNT_W-1:0] OPD_DEF = 20'h000C8;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TDIAL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_THR0 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_THR1 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_REL0 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_REL1 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_OPD0 = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_OPD1 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_OPCNT = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h2C;
	// control field positions
	localparam int C_DLY_REL = 0;
	localparam int C_RST_AFT = 1;
	localparam int C_CONT = 2;
	localparam int C_MAG_LO = 3;
	localparam int C_FEN = 5;
	localparam int C_FST_LO = 6;
	localparam int C_GRP = 8;
	localparam int C_RD = 9;
	localparam int CTRL_W = 10;
	localparam logic [CTRL_W-1:0] CTRL_DEF = 10'h003;
	// interrupt bits
	localparam int EV_START = 0;
	localparam int EV_TRIP = 1;
	localparam int EV_BLK = 2;
	localparam int EV_W = 3;
	// magnitude choice and stage condition
	typedef enum logic [1:0] {MAG_RMS, MAG_TRMS, MAG_PP, MAG_RSV} olt_mag_t;
	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} olt_cond_t;
endpackage : olt_pkg

// [rtl/olt_overload_timer.sv]
`timescale 1ns/1ps
// Behaviour
// - rd-type with dial below 0.3 and negative delay trips with no delay
// - delayed release holds start for release delay; otherwise start clears at drop
// - release delay 0 to 150 s in 5 ms steps, default 60 ms
// - counter clears after release expiry if enabled, else at pick-up drop
// - counter keeps counting during release when continue and reset-after options both set, else holds
// - default is 60 ms delayed release with counter held during release
// - counting during release never trips unless pick-up returns
// - forcing enable lets status be forced; force field visible only when enabled
// - measured currents still change state while forcing is enabled
// - one selectable magnitude: fundamental rms, true rms or peak-to-peak
// - phase magnitudes sampled and processed on the 5 ms tick
// - any phase above common threshold asserts pick-up
// - pick-up drops only below 97 percent of threshold
// - threshold in hundredths of nominal, default 1.20
// - setting group switches threshold and timing live
// - forced status and magnitude choice are outside setting groups
// - block at pick-up reports blocked; active start releases normally
module olt_overload_timer (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// measurement front end
	input  wire logic                        tick_5ms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l1_rms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l2_rms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l3_rms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l1_trms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l2_trms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l3_trms,
	input  wire logic [olt_pkg::MAG_W-1:0]   l1_pp,
	input  wire logic [olt_pkg::MAG_W-1:0]   l2_pp,
	input  wire logic [olt_pkg::MAG_W-1:0]   l3_pp,
	input  wire logic                        block_in,
	// register port
	input  wire logic [olt_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [olt_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [olt_pkg::DATA_W-1:0]  reg_rdata,
	// stage outputs
	output logic                             start_out,
	output logic                             trip_out,
	output logic                             blocked_out,
	output logic      [1:0]                  condition,
	output logic                             irq
);

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RELEASE, ST_TRIPPED} olt_state_t;

	localparam logic [olt_pkg::CNT_W-1:0] CNT_ONE = 20'h00001;
	localparam logic [olt_pkg::REL_W-1:0] REL_ONE = 15'h0001;

	// magnitude pick for one phase
	function automatic logic [olt_pkg::MAG_W-1:0] pick_mag(
		input logic [1:0]                  sel,
		input logic [olt_pkg::MAG_W-1:0]   rms,
		input logic [olt_pkg::MAG_W-1:0]   trms,
		input logic [olt_pkg::MAG_W-1:0]   pp
	);
		logic [olt_pkg::MAG_W-1:0] m;
		m = rms;
		if (sel == olt_pkg::MAG_TRMS)
			m = trms;
		else if (sel == olt_pkg::MAG_PP)
			m = pp;
		return m;
	endfunction : pick_mag

	// magnitude below drop-out level of threshold
	function automatic logic below_drop(
		input logic [olt_pkg::MAG_W-1:0]   mag,
		input logic [olt_pkg::MAG_W-1:0]   thr
	);
		logic [23:0] lhs;
		logic [23:0] rhs;
		lhs = 24'(mag) * 24'(olt_pkg::FULL_PCT);
		rhs = 24'(thr) * 24'(olt_pkg::DROP_PCT);
		return lhs < rhs;
	endfunction : below_drop

	// registers
	logic [olt_pkg::CTRL_W-1:0]  ctrl_r,   ctrl_nxt;
	logic [11:0]                 tdial_r,  tdial_nxt;
	logic [olt_pkg::MAG_W-1:0]   thr0_r,   thr0_nxt;
	logic [olt_pkg::MAG_W-1:0]   thr1_r,   thr1_nxt;
	logic [olt_pkg::REL_W-1:0]   rel0_r,   rel0_nxt;
	logic [olt_pkg::REL_W-1:0]   rel1_r,   rel1_nxt;
	logic [olt_pkg::CNT_W-1:0]   opd0_r,   opd0_nxt;
	logic [olt_pkg::CNT_W-1:0]   opd1_r,   opd1_nxt;
	logic [olt_pkg::EV_W-1:0]    istat_r,  istat_nxt;
	logic [olt_pkg::EV_W-1:0]    imask_r,  imask_nxt;
	logic [olt_pkg::DATA_W-1:0]  rdata_r,  rdata_nxt;
	// stage state
	olt_state_t                  state_r,  state_nxt;
	logic                        pick_r,   pick_nxt;
	logic                        blk_r,    blk_nxt;
	logic [olt_pkg::CNT_W-1:0]   opcnt_r,  opcnt_nxt;
	logic [olt_pkg::REL_W-1:0]   relcnt_r, relcnt_nxt;
	logic                        start_r,  start_nxt;
	logic                        trip_r,   trip_nxt;
	logic                        bout_r,   bout_nxt;
	logic [1:0]                  cond_r,   cond_nxt;
	// combinational helpers
	logic [olt_pkg::MAG_W-1:0]   thr;
	logic [olt_pkg::REL_W-1:0]   rel;
	logic [olt_pkg::CNT_W-1:0]   opd;
	logic [olt_pkg::CNT_W-1:0]   delay;
	logic [olt_pkg::MAG_W-1:0]   m1;
	logic [olt_pkg::MAG_W-1:0]   m2;
	logic [olt_pkg::MAG_W-1:0]   m3;
	logic                        eff_pick;
	logic                        st_meas;
	logic                        tr_meas;
	logic                        bl_meas;
	logic [1:0]                  fst;
	logic [olt_pkg::EV_W-1:0]    ev;

	// active setting group
	always_comb
	begin
		thr = ctrl_r[olt_pkg::C_GRP] ? thr1_r : thr0_r;
		rel = ctrl_r[olt_pkg::C_GRP] ? rel1_r : rel0_r;
		opd = ctrl_r[olt_pkg::C_GRP] ? opd1_r : opd0_r;
		delay = opd;
		// negative computed delay means trip at once
		if (opd[olt_pkg::CNT_W-1])
			delay = '0;
		if (ctrl_r[olt_pkg::C_RD] && (tdial_r < olt_pkg::TDIAL_RD_MIN) && opd[olt_pkg::CNT_W-1])
			delay = '0;
	end

	// selected magnitudes
	always_comb
	begin
		m1 = pick_mag(ctrl_r[olt_pkg::C_MAG_LO +: 2], l1_rms, l1_trms, l1_pp);
		m2 = pick_mag(ctrl_r[olt_pkg::C_MAG_LO +: 2], l2_rms, l2_trms, l2_pp);
		m3 = pick_mag(ctrl_r[olt_pkg::C_MAG_LO +: 2], l3_rms, l3_trms, l3_pp);
	end

	// pick-up with hysteresis and blocking, sampled on tick
	always_comb
	begin
		pick_nxt = pick_r;
		blk_nxt = blk_r;
		if (tick_5ms)
		begin
			if ((m1 > thr) || (m2 > thr) || (m3 > thr))
				pick_nxt = 1'b1;
			else if (below_drop(m1, thr) && below_drop(m2, thr) && below_drop(m3, thr))
				pick_nxt = 1'b0;
			// block caught at the moment pick-up asserts
			if (pick_nxt && !pick_r)
				blk_nxt = block_in;
			else if (!pick_nxt)
				blk_nxt = 1'b0;
		end
	end

	// pick-up that may run the timers
	assign eff_pick = pick_r && !blk_r && !block_in;

	// operating and release timing
	always_comb
	begin
		state_nxt = state_r;
		opcnt_nxt = opcnt_r;
		relcnt_nxt = relcnt_r;
		if (tick_5ms)
		begin
			case (state_r)
				ST_IDLE:
				begin
					opcnt_nxt = '0;
					if (eff_pick && (delay == '0))
						state_nxt = ST_TRIPPED;
					else if (eff_pick)
					begin
						state_nxt = ST_RUN;
						opcnt_nxt = CNT_ONE;
					end
				end
				ST_RUN:
				begin
					if (eff_pick)
					begin
						opcnt_nxt = opcnt_r + CNT_ONE;
						if (opcnt_r + CNT_ONE >= delay)
							state_nxt = ST_TRIPPED;
					end
					else
					begin
						relcnt_nxt = '0;
						if (!ctrl_r[olt_pkg::C_RST_AFT])
							opcnt_nxt = '0;
						if (rel == '0)
						begin
							state_nxt = ST_IDLE;
							opcnt_nxt = '0;
						end
						else
							state_nxt = ST_RELEASE;
					end
				end
				ST_RELEASE:
				begin
					if (eff_pick)
					begin
						// pick-up returned: resume, trip allowed again
						opcnt_nxt = opcnt_r + CNT_ONE;
						state_nxt = (opcnt_r + CNT_ONE >= delay) ? ST_TRIPPED : ST_RUN;
					end
					else
					begin
						relcnt_nxt = relcnt_r + REL_ONE;
						if (ctrl_r[olt_pkg::C_CONT] && ctrl_r[olt_pkg::C_RST_AFT] && (opcnt_r < delay))
							opcnt_nxt = opcnt_r + CNT_ONE;
						if (relcnt_r + REL_ONE >= rel)
						begin
							state_nxt = ST_IDLE;
							opcnt_nxt = '0;
						end
					end
				end
				ST_TRIPPED:
				begin
					if (!eff_pick)
					begin
						state_nxt = ST_IDLE;
						opcnt_nxt = '0;
					end
				end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	// measured and forced stage outputs
	always_comb
	begin
		st_meas = (state_r == ST_RUN) || ((state_r == ST_RELEASE) && ctrl_r[olt_pkg::C_DLY_REL]);
		tr_meas = (state_r == ST_TRIPPED);
		bl_meas = pick_r && blk_r;
		fst = ctrl_r[olt_pkg::C_FEN] ? ctrl_r[olt_pkg::C_FST_LO +: 2] : 2'(olt_pkg::COND_NORMAL);
		// forced value joins the measured one
		start_nxt = st_meas || (fst == olt_pkg::COND_START);
		trip_nxt = tr_meas || (fst == olt_pkg::COND_TRIP);
		bout_nxt = bl_meas || (fst == olt_pkg::COND_BLOCKED);
		if (bout_nxt)
			cond_nxt = olt_pkg::COND_BLOCKED;
		else if (trip_nxt)
			cond_nxt = olt_pkg::COND_TRIP;
		else if (start_nxt)
			cond_nxt = olt_pkg::COND_START;
		else
			cond_nxt = olt_pkg::COND_NORMAL;
	end

	// rising edges as interrupt events
	assign ev = {bout_nxt && !bout_r, trip_nxt && !trip_r, start_nxt && !start_r};

	// register writes, interrupt status with set winning over clear
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		tdial_nxt = tdial_r;
		thr0_nxt = thr0_r;
		thr1_nxt = thr1_r;
		rel0_nxt = rel0_r;
		rel1_nxt = rel1_r;
		opd0_nxt = opd0_r;
		opd1_nxt = opd1_r;
		imask_nxt = imask_r;
		istat_nxt = istat_r;
		if (reg_wr)
		begin
			if (reg_addr == olt_pkg::OFS_CTRL)
				ctrl_nxt = reg_wdata[olt_pkg::CTRL_W-1:0];
			else if (reg_addr == olt_pkg::OFS_TDIAL)
				tdial_nxt = reg_wdata[11:0];
			else if (reg_addr == olt_pkg::OFS_THR0)
				thr0_nxt = reg_wdata[olt_pkg::MAG_W-1:0];
			else if (reg_addr == olt_pkg::OFS_THR1)
				thr1_nxt = reg_wdata[olt_pkg::MAG_W-1:0];
			else if (reg_addr == olt_pkg::OFS_REL0)
				rel0_nxt = clamp_rel(reg_wdata);
			else if (reg_addr == olt_pkg::OFS_REL1)
				rel1_nxt = clamp_rel(reg_wdata);
			else if (reg_addr == olt_pkg::OFS_OPD0)
				opd0_nxt = reg_wdata[olt_pkg::CNT_W-1:0];
			else if (reg_addr == olt_pkg::OFS_OPD1)
				opd1_nxt = reg_wdata[olt_pkg::CNT_W-1:0];
			else if (reg_addr == olt_pkg::OFS_ISTAT)
				istat_nxt = istat_r & ~reg_wdata[olt_pkg::EV_W-1:0];
			else if (reg_addr == olt_pkg::OFS_IMASK)
				imask_nxt = reg_wdata[olt_pkg::EV_W-1:0];
		end
		istat_nxt = istat_nxt | ev;
	end

	// release delay limited to its range, whole word judged so high bits cannot wrap
	function automatic logic [olt_pkg::REL_W-1:0] clamp_rel(input logic [olt_pkg::DATA_W-1:0] v);
		return ((|v[olt_pkg::DATA_W-1:olt_pkg::REL_W]) || (v[olt_pkg::REL_W-1:0] > olt_pkg::REL_MAX))
			? olt_pkg::REL_MAX : v[olt_pkg::REL_W-1:0];
	endfunction : clamp_rel

	// read data, one cycle after the strobe
	always_comb
	begin
		rdata_nxt = '0;
		if (reg_rd)
		begin
			if (reg_addr == olt_pkg::OFS_CTRL)
			begin
				rdata_nxt[olt_pkg::CTRL_W-1:0] = ctrl_r;
				if (!ctrl_r[olt_pkg::C_FEN])
					rdata_nxt[olt_pkg::C_FST_LO +: 2] = 2'h0;
			end
			else if (reg_addr == olt_pkg::OFS_TDIAL)
				rdata_nxt[11:0] = tdial_r;
			else if (reg_addr == olt_pkg::OFS_THR0)
				rdata_nxt[olt_pkg::MAG_W-1:0] = thr0_r;
			else if (reg_addr == olt_pkg::OFS_THR1)
				rdata_nxt[olt_pkg::MAG_W-1:0] = thr1_r;
			else if (reg_addr == olt_pkg::OFS_REL0)
				rdata_nxt[olt_pkg::REL_W-1:0] = rel0_r;
			else if (reg_addr == olt_pkg::OFS_REL1)
				rdata_nxt[olt_pkg::REL_W-1:0] = rel1_r;
			else if (reg_addr == olt_pkg::OFS_OPD0)
				rdata_nxt[olt_pkg::CNT_W-1:0] = opd0_r;
			else if (reg_addr == olt_pkg::OFS_OPD1)
				rdata_nxt[olt_pkg::CNT_W-1:0] = opd1_r;
			else if (reg_addr == olt_pkg::OFS_STAT)
				rdata_nxt[7:0] = {pick_r, bout_r, trip_r, start_r, state_r, cond_r};
			else if (reg_addr == olt_pkg::OFS_OPCNT)
				rdata_nxt[olt_pkg::CNT_W-1:0] = opcnt_r;
			else if (reg_addr == olt_pkg::OFS_ISTAT)
				rdata_nxt[olt_pkg::EV_W-1:0] = istat_r;
			else if (reg_addr == olt_pkg::OFS_IMASK)
				rdata_nxt[olt_pkg::EV_W-1:0] = imask_r;
		end
	end

	// state registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl_r <= olt_pkg::CTRL_DEF;
			tdial_r <= olt_pkg::TDIAL_DEF;
			thr0_r <= olt_pkg::THR_DEF;
			thr1_r <= olt_pkg::THR_DEF;
			rel0_r <= olt_pkg::REL_DEF;
			rel1_r <= olt_pkg::REL_DEF;
			opd0_r <= olt_pkg::OPD_DEF;
			opd1_r <= olt_pkg::OPD_DEF;
			istat_r <= '0;
			imask_r <= '0;
			rdata_r <= '0;
			state_r <= ST_IDLE;
			pick_r <= 1'b0;
			blk_r <= 1'b0;
			opcnt_r <= '0;
			relcnt_r <= '0;
			start_r <= 1'b0;
			trip_r <= 1'b0;
			bout_r <= 1'b0;
			cond_r <= olt_pkg::COND_NORMAL;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			tdial_r <= tdial_nxt;
			thr0_r <= thr0_nxt;
			thr1_r <= thr1_nxt;
			rel0_r <= rel0_nxt;
			rel1_r <= rel1_nxt;
			opd0_r <= opd0_nxt;
			opd1_r <= opd1_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			pick_r <= pick_nxt;
			blk_r <= blk_nxt;
			opcnt_r <= opcnt_nxt;
			relcnt_r <= relcnt_nxt;
			start_r <= start_nxt;
			trip_r <= trip_nxt;
			bout_r <= bout_nxt;
			cond_r <= cond_nxt;
		end
	end

	// outputs
	assign reg_rdata = rdata_r;
	assign start_out = start_r;
	assign trip_out = trip_r;
	assign blocked_out = bout_r;
	assign condition = cond_r;
	assign irq = |(istat_r & imask_r);

endmodule : olt_overload_timer

// [bench/olt_monitor.sv]
`timescale 1ns/1ps
module olt_monitor (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       reset,
	// stimulus side
	input wire logic                       tick_5ms,
	input wire logic [olt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [olt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	// design outputs
	input wire logic [olt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                       start_out,
	input wire logic                       trip_out,
	input wire logic                       blocked_out,
	input wire logic [1:0]                 condition,
	input wire logic                       irq
);
	logic [3:0] fen_r;
	logic [2:0] mask_r;
	logic       calm;

	// snoop force enable history and interrupt mask
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fen_r  <= 4'h0;
			mask_r <= 3'h0;
		end
		else
		begin
			fen_r <= {fen_r[2:0], (reg_wr && reg_addr == olt_pkg::OFS_CTRL) ? reg_wdata[5] : fen_r[0]};
			if (reg_wr && reg_addr == olt_pkg::OFS_IMASK)
				mask_r <= reg_wdata[2:0];
		end
	end

	// forced outputs need a few cycles to settle
	assign calm = (fen_r == 4'h0);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside its slot");
	AST_UNMAPPED_RD: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	AST_FORCE_HIDDEN: assert property (reg_rd && reg_addr == olt_pkg::OFS_CTRL && !fen_r[0] |=> reg_rdata[7:6] == 2'h0)
		else $error("force field visible while forcing off");
	AST_MASK_OFF: assert property (mask_r == 3'h0 |-> !irq)
		else $error("interrupt with all events masked");
	AST_RESET_QUIET: assert property ($fell(reset) |-> !start_out && !trip_out && !blocked_out && condition == 2'h0)
		else $error("outputs active after reset");
	AST_COND_PRIO: assert property (calm |-> condition == (blocked_out ? 2'h3 : trip_out ? 2'h2 : start_out ? 2'h1 : 2'h0))
		else $error("condition code disagrees with outputs");
	AST_START_RISE: assert property (calm && $rose(start_out) |-> $past(tick_5ms, 2))
		else $error("start rose off the tick");
	AST_START_FALL: assert property (calm && $fell(start_out) |-> $past(tick_5ms, 2))
		else $error("start fell off the tick");
	AST_TRIP_RISE: assert property (calm && $rose(trip_out) |-> $past(tick_5ms, 2))
		else $error("trip rose off the tick");
endmodule : olt_monitor

// [bench/olt_front_end.sv]
`timescale 1ns/1ps
module olt_front_end #(
	parameter int TICK_CYC = 8
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// measurement outputs
	output logic                      tick_5ms,
	output logic [olt_pkg::MAG_W-1:0] mag [0:8]
);
	logic [olt_pkg::MAG_W-1:0] pend [0:8];
	int                        cnt;

	// quiet outputs before the first edge
	initial
	begin
		pend     = '{default: '0};
		mag      = '{default: '0};
		tick_5ms = 1'b0;
	end

	// new values wait for the next refresh
	task automatic set_mag(input int idx, input logic [olt_pkg::MAG_W-1:0] v);
		pend[idx] = v;
	endtask : set_mag

	// tick pulse with magnitudes refreshed on it
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt      <= 0;
			tick_5ms <= 1'b0;
		end
		else
		begin
			cnt      <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
			tick_5ms <= (cnt == TICK_CYC - 1);
			if (cnt == TICK_CYC - 1)
				mag <= pend;
		end
	end
endmodule : olt_front_end

// [bench/tb_overload_pickup_release_timer.sv]
`timescale 1ns/1ps
module tb_overload_pickup_release_timer;
	logic                       clk       = 1'b0;
	logic                       reset     = 1'b1;
	logic                       tick_5ms;
	logic [olt_pkg::MAG_W-1:0]  m [0:8];
	logic                       block_in  = 1'b0;
	logic [olt_pkg::ADDR_W-1:0] reg_addr  = 8'h00;
	logic [olt_pkg::DATA_W-1:0] reg_wdata = 32'h00000000;
	logic                       reg_wr    = 1'b0;
	logic                       reg_rd    = 1'b0;
	logic [olt_pkg::DATA_W-1:0] reg_rdata;
	logic                       start_out, trip_out, blocked_out, irq;
	logic [1:0]                 condition;
	logic [31:0]                d, a;
	int                         num_errors = 0;
	int                         n_compared = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// front end and device
	olt_front_end #(.TICK_CYC(8)) fe (.clk(clk), .reset(reset), .tick_5ms(tick_5ms), .mag(m));
	olt_overload_timer dut (
		.clk(clk), .reset(reset), .tick_5ms(tick_5ms), .block_in(block_in),
		.l1_rms(m[0]), .l2_rms(m[1]), .l3_rms(m[2]), .l1_trms(m[3]), .l2_trms(m[4]), .l3_trms(m[5]),
		.l1_pp(m[6]), .l2_pp(m[7]), .l3_pp(m[8]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out), .condition(condition), .irq(irq)
	);

	// shared checks and bus cycles
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= ad;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input string msg);
		rd(ad, d);
		chk(d === e, msg);
	endtask : rdc
	// wait n sampled ticks, then let outputs register
	task automatic tk(input int n);
		repeat (n) @(posedge clk iff tick_5ms === 1'b1);
		repeat (2) @(posedge clk);
		#1;
	endtask : tk

	task automatic t_regs;
		rdc(olt_pkg::OFS_CTRL, 32'h00000003, "ctrl default");
		rdc(olt_pkg::OFS_THR0, 32'h00000078, "threshold default");
		rdc(olt_pkg::OFS_REL0, 32'h0000000C, "release default");
		rdc(olt_pkg::OFS_STAT, 32'h00000000, "status idle");
		wr(8'h30, 32'h0000FFFF);
		rdc(8'h30, 32'h00000000, "unmapped place");
		wr(olt_pkg::OFS_REL1, 32'h00010005);
		rdc(olt_pkg::OFS_REL1, 32'h00007530, "wide release clamp");
		wr(olt_pkg::OFS_REL1, 32'h0000FFFF);
		rdc(olt_pkg::OFS_REL1, 32'h00007530, "release clamp");
		$display("t_regs done");
	endtask : t_regs

	task automatic t_hyst;
		wr(olt_pkg::OFS_REL0, 32'h00000003);
		wr(olt_pkg::OFS_OPD0, 32'h00000FFF);
		tk(1);
		fe.set_mag(1, 16'h0079);
		tk(3);
		chk(start_out === 1'b1, "single phase pick-up");
		fe.set_mag(1, 16'h0075);
		tk(4);
		chk(start_out === 1'b1, "dropped above 97 percent");
		fe.set_mag(1, 16'h0074);
		tk(3);
		chk(start_out === 1'b1, "start held in release");
		tk(4);
		chk(start_out === 1'b0, "start ends after release");
		wr(olt_pkg::OFS_THR1, 32'h000000C8);
		wr(olt_pkg::OFS_CTRL, 32'h00000103);
		fe.set_mag(1, 16'h0096);
		tk(4);
		chk(start_out === 1'b0, "group one threshold");
		wr(olt_pkg::OFS_CTRL, 32'h00000003);
		tk(3);
		chk(start_out === 1'b1, "group zero threshold");
		fe.set_mag(1, 16'h0000);
		tk(8);
		$display("t_hyst done");
	endtask : t_hyst

	task automatic t_mag;
		for (int k = 0; k < 3; k++)
		begin
			wr(olt_pkg::OFS_CTRL, 32'h00000003 | 32'(k << 3));
			fe.set_mag(((k + 1) % 3) * 3 + k, 16'h00C8);
			tk(4);
			chk(start_out === 1'b0, "unselected magnitude");
			fe.set_mag(k * 3 + k, 16'h00C8);
			tk(3);
			chk(start_out === 1'b1, "selected magnitude");
			fe.set_mag(k * 3 + k, 16'h0000);
			fe.set_mag(((k + 1) % 3) * 3 + k, 16'h0000);
			tk(8);
		end
		wr(olt_pkg::OFS_CTRL, 32'h0000001B);
		fe.set_mag(0, 16'h00C8);
		tk(3);
		chk(start_out === 1'b1, "spare code acts as rms");
		fe.set_mag(0, 16'h0000);
		tk(8);
		wr(olt_pkg::OFS_CTRL, 32'h00000003);
		$display("t_mag done");
	endtask : t_mag

	task automatic t_count;
		wr(olt_pkg::OFS_OPD0, 32'h00000008);
		wr(olt_pkg::OFS_REL0, 32'h00000004);
		for (int i = 0; i < 4; i++)
		begin
			wr(olt_pkg::OFS_CTRL, i == 1 ? 32'h00000001 : i == 2 ? 32'h00000007 : i == 3 ? 32'h00000002 : 32'h00000003);
			tk(1);
			fe.set_mag(0, 16'h00C8);
			tk(4);
			fe.set_mag(0, 16'h0000);
			tk(2);
			rd(olt_pkg::OFS_OPCNT, a);
			chk(start_out === (i != 3), "start in release per option");
			tk(1);
			rd(olt_pkg::OFS_OPCNT, d);
			chk((i == 0 || i == 3) ? (a === d && a !== 32'h0) : i == 1 ? (a === 32'h0 && d === 32'h0) : d === a + 32'h1,
				"op counter in release");
			tk(5);
			rdc(olt_pkg::OFS_OPCNT, 32'h00000000, "op counter after release");
			chk(trip_out === 1'b0 && start_out === 1'b0, "no trip without return");
		end
		wr(olt_pkg::OFS_CTRL, 32'h00000003);
		$display("t_count done");
	endtask : t_count

	task automatic t_trip;
		wr(olt_pkg::OFS_OPD0, 32'h00000004);
		tk(1);
		fe.set_mag(2, 16'h00C8);
		tk(4);
		chk(trip_out === 1'b0, "trip too early");
		tk(1);
		chk(trip_out === 1'b1, "trip at delay");
		rd(olt_pkg::OFS_STAT, d);
		chk(d[1:0] === 2'h2 && d[5] === 1'b1, "status trip");
		fe.set_mag(2, 16'h0000);
		tk(8);
		wr(olt_pkg::OFS_CTRL, 32'h00000203);
		wr(olt_pkg::OFS_TDIAL, 32'h0000001D);
		wr(olt_pkg::OFS_OPD0, 32'h000FFFFF);
		tk(1);
		fe.set_mag(2, 16'h00C8);
		tk(2);
		chk(trip_out === 1'b1, "instant trip");
		fe.set_mag(2, 16'h0000);
		tk(8);
		wr(olt_pkg::OFS_CTRL, 32'h00000003);
		wr(olt_pkg::OFS_OPD0, 32'h00000FFF);
		$display("t_trip done");
	endtask : t_trip

	task automatic t_block;
		wr(olt_pkg::OFS_ISTAT, 32'h00000007);
		wr(olt_pkg::OFS_IMASK, 32'h00000004);
		@(posedge clk);
		block_in <= 1'b1;
		fe.set_mag(0, 16'h00C8);
		tk(3);
		chk(blocked_out === 1'b1 && start_out === 1'b0 && condition === 2'h3, "blocked at pick-up");
		chk(irq === 1'b1, "blocked interrupt");
		fe.set_mag(0, 16'h0000);
		tk(8);
		@(posedge clk);
		block_in <= 1'b0;
		wr(olt_pkg::OFS_ISTAT, 32'h00000004);
		chk(irq === 1'b0, "interrupt cleared");
		fe.set_mag(0, 16'h00C8);
		tk(3);
		chk(start_out === 1'b1, "start before block");
		@(posedge clk);
		block_in <= 1'b1;
		tk(7);
		chk(start_out === 1'b0, "start released by block");
		chk(irq === 1'b0, "start event masked");
		wr(olt_pkg::OFS_IMASK, 32'h00000001);
		chk(irq === 1'b1, "start event unmasked");
		wr(olt_pkg::OFS_ISTAT, 32'h00000001);
		chk(irq === 1'b0, "start event cleared");
		@(posedge clk);
		block_in <= 1'b0;
		fe.set_mag(0, 16'h0000);
		tk(8);
		$display("t_block done");
	endtask : t_block

	task automatic t_force;
		wr(olt_pkg::OFS_CTRL, 32'h00000083);
		rdc(olt_pkg::OFS_CTRL, 32'h00000003, "force field hidden");
		wr(olt_pkg::OFS_CTRL, 32'h000000A3);
		tk(1);
		chk(trip_out === 1'b1, "forced trip");
		rdc(olt_pkg::OFS_CTRL, 32'h000000A3, "force field shown");
		wr(olt_pkg::OFS_CTRL, 32'h00000023);
		fe.set_mag(1, 16'h00C8);
		tk(3);
		chk(start_out === 1'b1, "measured start while forcing");
		fe.set_mag(1, 16'h0000);
		wr(olt_pkg::OFS_CTRL, 32'h00000003);
		tk(8);
		$display("t_force done");
	endtask : t_force

	// verdict and end of run
	task automatic finish_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_hyst;
		t_mag;
		t_count;
		t_trip;
		t_block;
		t_force;
		finish_test;
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test;
	end
endmodule : tb_overload_pickup_release_timer

bind olt_overload_timer olt_monitor mon (
	.clk(clk), .reset(reset), .tick_5ms(tick_5ms), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out),
	.trip_out(trip_out), .blocked_out(blocked_out), .condition(condition), .irq(irq)
);
